// ### rtl/qdac_pkg.sv
// Function
// - Channel codes are unsigned binary 0 to 255.
// - Slave at standard, fast, high-speed rates.
// - Only 7-bit addresses; no general call.
// - SDA falling while SCL high starts transfer.
// - Stop releases bus; await start and address.
// - Matching address acked low through ninth high.
// - Units are eight bits plus acknowledge.
// - Master code unacked but enters high-speed mode.
// - Repeated starts keep high speed; stop leaves.
// - Address, control, MSB, LSB bytes each acked; code leaves LSB unacked while the update queue is full.
// - Update at falling edge ending LSB ack; code queues it there and applies it once CONV_READY_I is high.
// - Control byte retained; further MSB/LSB pairs update.
// - Code from MSB byte; LSB byte ignored.
// - Address is 10011, select pins, direction.
// - Select pins captured at power-up.
// - Broadcast byte 1001 0000 always accepted.
// - Broadcast accepted for writes only.
// - First byte after address is control.
// - Update only when extended address matches, except broadcast.
// - Load mode 00 writes temporary register only.
// - Load mode 01 writes temporary and output.
// - Load mode 10 also loads others from temporary.
package qdac_pkg;
  localparam int          CODE_W     = 8;
  localparam int          NUM_CH     = 4;
  localparam int          SYNC_W     = 6;
  localparam int          FIFO_DEPTH = 8;
  localparam int          SY_SCL     = 5;
  localparam int          SY_SDA     = 4;
  localparam int          SY_DSH     = 3;
  localparam int          SY_DSL     = 2;
  localparam int          SY_EXH     = 1;
  localparam int          SY_EXL     = 0;
  localparam logic [4:0]  ADDR_FIXED = 5'h13;
  localparam logic [4:0]  MCODE_PFX  = 5'h01;
  localparam logic [7:0]  BCAST_WR   = 8'h90;
  localparam logic [3:0]  CNT_BYTE   = 4'h8;
  localparam logic [3:0]  CNT_ACK    = 4'h9;
  localparam logic [1:0]  LM_TEMP    = 2'h0;
  localparam logic [1:0]  LM_BOTH    = 2'h1;
  localparam logic [1:0]  LM_SYNC    = 2'h2;
  localparam logic [1:0]  LM_BCAST   = 2'h3;
  localparam logic [1:0]  STRAP_AT   = 2'h2;

  typedef struct packed {logic [4:0] fixed; logic [1:0] dsel; logic rw;} qdac_addr_t;
  typedef struct packed {
    logic [1:0] ext;
    logic [1:0] load;
    logic       unused;
    logic [1:0] sel;
    logic       pd;
  } qdac_ctrl_t;
  typedef struct packed {qdac_ctrl_t ctrl; logic [CODE_W-1:0] code;} qdac_upd_t;
  typedef struct packed {logic pd; logic [CODE_W-1:0] code;} qdac_chan_t;
  typedef enum logic [3:0] {S_IDLE = 4'h1, S_ADDR = 4'h2, S_WRITE = 4'h4, S_READ = 4'h8}
    qdac_state_t;
  typedef enum logic [2:0] {R_CTRL = 3'h1, R_MSB = 3'h2, R_LSB = 3'h4} qdac_role_t;
endpackage : qdac_pkg

// ### rtl/qdac_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module qdac_fifo
  import qdac_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_ni,
  // Filling side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              wr_w = in_valid_i & in_ready_o;
  wire              rd_w = out_valid_o & out_ready_i;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  // Storage has no reset; only pointers and count carry state.
  always_ff @(posedge clk_i)
  begin
    if (wr_w) mem_q[wr_q] <= in_data_i;
  end

  // Pointer wrap relies on a power-of-two depth.
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (wr_w) wr_q <= wr_q + 1'b1;
      if (rd_w) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(wr_w) - (AW+1)'(rd_w);
    end
  end
endmodule : qdac_fifo
`default_nettype wire

// ### rtl/qdac_i2c_port.sv
`timescale 1ns/1ns
`default_nettype none
module qdac_i2c_port
  import qdac_pkg::*;
(
  // Core clock and asynchronous active-low reset.
  input  wire logic       CORE_CLK_I,
  input  wire logic       RSTN_I,
  // Two-wire bus, SDA as open-drain triple.
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Address straps and extended address pins.
  input  wire logic       DEVICE_SELECT_HI_PIN_I,
  input  wire logic       DEVICE_SELECT_LO_PIN_I,
  input  wire logic       EXT_ADDR_HI_PIN_I,
  input  wire logic       EXT_ADDR_LO_PIN_I,
  // Converter side.
  input  wire logic       CONV_READY_I,
  output qdac_chan_t [NUM_CH-1:0] CHAN_O,
  output logic            UPDATE_O,
  output logic            HS_MODE_O
);
  // ************************************************************
  // Reset release and input synchronisers
  // ************************************************************
  logic              rst_s1_q;
  logic              rst_n;
  logic [SYNC_W-1:0] syn1_q;
  logic [SYNC_W-1:0] syn2_q;
  logic              scl_p_q;
  logic              sda_p_q;

  // Reset asserts at once but releases two edges later.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Every pin passes two flops; the first stage feeds only the second.
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syn1_q  <= {SYNC_W{1'b1}};
      syn2_q  <= {SYNC_W{1'b1}};
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      syn1_q  <= {SCL_I, SDA_I, DEVICE_SELECT_HI_PIN_I, DEVICE_SELECT_LO_PIN_I,
                  EXT_ADDR_HI_PIN_I, EXT_ADDR_LO_PIN_I};
      syn2_q  <= syn1_q;
      scl_p_q <= syn2_q[SY_SCL];
      sda_p_q <= syn2_q[SY_SDA];
    end
  end

  // ************************************************************
  // Bus event decode
  // ************************************************************
  wire scl_w     = syn2_q[SY_SCL];
  wire sda_w     = syn2_q[SY_SDA];
  wire scl_rise  = scl_w & ~scl_p_q;
  wire scl_fall  = ~scl_w & scl_p_q;
  wire start_w   = scl_w & scl_p_q & sda_p_q & ~sda_w;
  wire stop_w    = scl_w & scl_p_q & ~sda_p_q & sda_w;
  wire [1:0] ext_w = {syn2_q[SY_EXH], syn2_q[SY_EXL]};

  // ************************************************************
  // Strap capture
  // ************************************************************
  logic [1:0] strap_cnt_q;
  logic [1:0] dsel_q;

  // Waits until the synchroniser holds pin levels, then freezes them.
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt_q <= '0;
      dsel_q      <= '0;
    end
    else if (strap_cnt_q != STRAP_AT + 2'h1)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_AT)
        dsel_q <= {syn2_q[SY_DSH], syn2_q[SY_DSL]};
    end
  end

  // ************************************************************
  // Byte engine
  // ************************************************************
  qdac_state_t       st_q;
  qdac_role_t        role_q;
  logic [3:0]        cnt_q;
  logic [CODE_W-1:0] shift_q;
  logic [CODE_W-1:0] tx_q;
  logic [CODE_W-1:0] msb_q;
  qdac_ctrl_t        ctrl_q;
  logic              oe_q;
  logic              ack_q;
  logic              mack_q;
  logic              hs_q;
  logic              bcast_q;
  logic              fifo_ready;
  qdac_chan_t [NUM_CH-1:0] dac_q;

  // Own address or broadcast write; nothing for 10-bit or general call.
  function automatic logic addr_hit(input logic [CODE_W-1:0] b, input logic [1:0] ds);
    qdac_addr_t a;
    a = qdac_addr_t'(b);
    addr_hit = (a.fixed == ADDR_FIXED && a.dsel == ds) || b == BCAST_WR;
  endfunction : addr_hit

  // Byte-level decode.
  qdac_addr_t addr_w;
  assign addr_w = qdac_addr_t'(shift_q);
  wire hit_w    = addr_hit(shift_q, dsel_q);
  wire mcode_w  = addr_w.fixed == MCODE_PFX;
  wire slot_beg = scl_fall & (cnt_q == CNT_BYTE);
  wire slot_end = scl_fall & (cnt_q == CNT_ACK);
  wire in_frame = st_q != S_IDLE;
  wire ack_d    = (st_q == S_ADDR) ? hit_w : (role_q != R_LSB) | fifo_ready;
  wire permit_w = ctrl_q.load == LM_BCAST || ctrl_q.ext == ext_w;
  wire push_w   = slot_end & (st_q == S_WRITE) & (role_q == R_LSB) & ack_q & permit_w;
  wire [CODE_W-1:0] tx_code_w = dac_q[ctrl_q.sel].code;

  // Frame sequencing; a start or stop overrides whatever phase is running.
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q    <= S_IDLE;
      role_q  <= R_CTRL;
      cnt_q   <= '0;
      oe_q    <= 1'b0;
      ack_q   <= 1'b0;
      hs_q    <= 1'b0;
      bcast_q <= 1'b0;
    end
    else if (start_w)
    begin
      st_q  <= S_ADDR;
      cnt_q <= '0;
      oe_q  <= 1'b0;
    end
    else if (stop_w)
    begin
      st_q  <= S_IDLE;
      oe_q  <= 1'b0;
      hs_q  <= 1'b0;
    end
    else if (in_frame && scl_rise)
      cnt_q <= cnt_q + 4'h1;
    else if (in_frame && slot_beg)
    begin
      if (st_q == S_READ)
        oe_q <= 1'b0;
      else
      begin
        ack_q <= ack_d & ~(st_q == S_ADDR & mcode_w);
        oe_q  <= ack_d & ~(st_q == S_ADDR & mcode_w);
        if (st_q == S_ADDR && mcode_w)
          hs_q <= 1'b1;
        if (st_q == S_ADDR && (!hit_w || mcode_w))
          st_q <= S_IDLE;
      end
    end
    else if (in_frame && slot_end)
    begin
      cnt_q <= '0;
      case (st_q)
        S_ADDR:
        begin
          st_q    <= addr_w.rw ? S_READ : S_WRITE;
          bcast_q <= shift_q == BCAST_WR;
          role_q  <= R_CTRL;
          oe_q    <= addr_w.rw & ~tx_code_w[CODE_W-1];
        end
        S_WRITE:
        begin
          oe_q   <= 1'b0;
          role_q <= (role_q == R_MSB) ? R_LSB : R_MSB;
        end
        S_READ:
        begin
          oe_q <= mack_q & ~tx_code_w[CODE_W-1];
          if (!mack_q)
            st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
    else if (in_frame && scl_fall && st_q == S_READ)
      oe_q <= ~tx_q[CODE_W-1];
  end

  // Shift registers and captured bytes.
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= '0;
      tx_q    <= '0;
      msb_q   <= '0;
      mack_q  <= 1'b0;
      ctrl_q  <= '0;
    end
    else
    begin
      if (in_frame && scl_rise && cnt_q < CNT_BYTE)
        shift_q <= {shift_q[CODE_W-2:0], sda_w};
      if (st_q == S_READ && scl_rise && cnt_q == CNT_BYTE)
        mack_q <= ~sda_w;
      if (slot_end && st_q != S_WRITE)
        tx_q <= {tx_code_w[CODE_W-2:0], 1'b0};
      else if (st_q == S_READ && scl_fall && cnt_q < CNT_BYTE)
        tx_q <= {tx_q[CODE_W-2:0], 1'b0};
      if (slot_beg && st_q == S_WRITE && role_q == R_CTRL)
        ctrl_q <= qdac_ctrl_t'(shift_q);
      if (slot_beg && st_q == S_WRITE && role_q == R_MSB)
        msb_q <= shift_q;
    end
  end

  assign SDA_O     = 1'b0;
  assign SDA_OE_O  = oe_q;
  assign HS_MODE_O = hs_q;

  // ************************************************************
  // Update queue and channel registers
  // ************************************************************
  qdac_upd_t  upd_w;
  logic       upd_valid;
  qdac_chan_t new_w;
  qdac_chan_t [NUM_CH-1:0] tmp_q;
  logic       apply_w;
  logic       update_q;

  // A full queue withholds the LSB acknowledge, so the master sees it.
  qdac_fifo #(.WIDTH($bits(qdac_upd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_ni      (rst_n),
    .in_valid_i  (push_w),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({ctrl_q, msb_q}),
    .out_valid_o (upd_valid),
    .out_ready_i (CONV_READY_I),
    .out_data_o  (upd_w)
  );

  assign apply_w = upd_valid & CONV_READY_I;
  assign new_w   = '{pd: upd_w.ctrl.pd, code: upd_w.code};

  // Per-channel load decisions from the queued load mode.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      wire sel_w  = upd_w.ctrl.sel == 2'(gi);
      wire bc_new = upd_w.ctrl.load == LM_BCAST & upd_w.ctrl.sel[1];
      wire bc_old = upd_w.ctrl.load == LM_BCAST & ~upd_w.ctrl.sel[1];
      // Broadcast from temporary ignores the channel pick, so the new code is dropped.
      wire wr_tmp = apply_w & ((sel_w & ~bc_old) | bc_new);
      wire wr_new = apply_w & ((sel_w & ~bc_old & upd_w.ctrl.load != LM_TEMP)
                    | bc_new);
      wire wr_old = apply_w & ((~sel_w & upd_w.ctrl.load == LM_SYNC) | bc_old);

      // Outputs start at zero and hold until a valid update.
      always_ff @(posedge CORE_CLK_I or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tmp_q[gi] <= '0;
          dac_q[gi] <= '0;
        end
        else
        begin
          if (wr_tmp) tmp_q[gi] <= new_w;
          if (wr_new) dac_q[gi] <= new_w;
          else if (wr_old) dac_q[gi] <= tmp_q[gi];
        end
      end
    end
  endgenerate

  // One cycle high per applied update; back-to-back updates merge into one longer pulse.
  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n) update_q <= 1'b0;
    else update_q <= apply_w;
  end

  assign CHAN_O   = dac_q;
  assign UPDATE_O = update_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_addr_done;
    st_q == S_ADDR && slot_beg && !start_w && !stop_w;
  endsequence
  sequence s_lsb_end;
    push_w && !start_w && !stop_w;
  endsequence

  start_entry_a: assert property (start_w |=> st_q == S_ADDR && !oe_q)
    else $error("start not taken");
  stop_release_a: assert property (stop_w |=> st_q == S_IDLE && !oe_q && !hs_q)
    else $error("stop did not release");
  addr_ack_a: assert property (s_addr_done ##0 (hit_w && !mcode_w) |=> oe_q)
    else $error("matching address not acked");
  mcode_noack_a: assert property (s_addr_done ##0 mcode_w |=> !oe_q && hs_q)
    else $error("master code handled wrongly");
  ack_hold_a: assert property (st_q == S_WRITE && ack_q && scl_rise && cnt_q == CNT_BYTE
    |-> oe_q ##1 oe_q)
    else $error("ack released in high phase");
  bcast_read_a: assert property (st_q == S_READ |-> !bcast_q)
    else $error("broadcast read answered");
  push_room_a: assert property (s_lsb_end |-> fifo_ready && permit_w)
    else $error("update pushed without room");
  ctrl_keep_a: assert property (!$stable(ctrl_q)
    |-> $past(role_q) == R_CTRL && $past(slot_beg))
    else $error("control byte changed outside its slot");
  temp_only_a: assert property (apply_w && upd_w.ctrl.load == LM_TEMP |=> $stable(dac_q))
    else $error("output changed in temporary mode");
  direct_load_a: assert property (apply_w && upd_w.ctrl.load == LM_BOTH
    |=> dac_q[$past(upd_w.ctrl.sel)].code == $past(upd_w.code) && update_q)
    else $error("selected output not loaded");
endmodule : qdac_i2c_port
`default_nettype wire

// ### test/qdac_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module qdac_i2c_master
(
  // Bus wires of the master.
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // ********************
  // Two-wire bus master model
  // ********************
  localparam int HALF = 32;

  // The bus idles with the clock high and data left to the pull-up.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Data moves 8 ns after a clock fall, so no edge is ever mistaken for a stop.
  task automatic start();
    #8 sda_o = 1'b1;
    #(HALF - 8) scl_o = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask : start

  // The trailing idle gives the device a bus-free time before the next start.
  task automatic stop();
    #8 sda_o = 1'b0;
    #(HALF - 8) scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #(2 * HALF);
  endtask : stop

  // Sampling in mid and late high phase catches a line that lets go too soon.
  task automatic clk_bit(input logic b, output logic s);
    #8 sda_o = b;
    #(HALF - 8) scl_o = 1'b1;
    #(HALF / 2) s = sda_i;
    #(HALF / 2 - 1) s = s | sda_i;
    #1 scl_o = 1'b0;
  endtask : clk_bit

  // Eight bits MSB first, then the receiver's acknowledge.
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : write_byte

  // The master answers a read byte with its own acknowledge bit.
  task automatic read_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, b[i]);
    clk_bit(~mack, s);
  endtask : read_byte
endmodule : qdac_i2c_master
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import qdac_pkg::*;
;
  // ********************
  // Stimulus and checks
  // ********************
  logic                    core_clk = 1'b0;
  logic                    rst_n    = 1'b0;
  logic [1:0]              dsel     = 2'h2;
  logic [1:0]              ext      = 2'h0;
  logic                    conv_rdy = 1'b1;
  logic                    scl;
  logic                    sda_m;
  logic                    sda_w;
  logic                    sda_dev;
  logic                    sda_oe;
  logic                    upd;
  logic                    hs;
  qdac_chan_t [NUM_CH-1:0] chan;
  int                      errors      = 0;
  int                      checks_done = 0;

  // Open-drain wire with pull-up: low when either party pulls it.
  assign sda_w = sda_m & ~(sda_oe & ~sda_dev);

  // Core clock, 8 ns period.
  always #4 core_clk = ~core_clk;

  qdac_i2c_port u_qdac_i2c_port (
    .CORE_CLK_I(core_clk), .RSTN_I(rst_n), .SCL_I(scl), .SDA_I(sda_w),
    .SDA_O(sda_dev), .SDA_OE_O(sda_oe), .DEVICE_SELECT_HI_PIN_I(dsel[1]),
    .DEVICE_SELECT_LO_PIN_I(dsel[0]), .EXT_ADDR_HI_PIN_I(ext[1]),
    .EXT_ADDR_LO_PIN_I(ext[0]), .CONV_READY_I(conv_rdy), .CHAN_O(chan),
    .UPDATE_O(upd), .HS_MODE_O(hs));

  qdac_i2c_master u_qdac_i2c_master (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic check_val(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic sta();
    u_qdac_i2c_master.start();
  endtask : sta

  task automatic sto();
    u_qdac_i2c_master.stop();
  endtask : sto

  // Sends one byte and judges the acknowledge seen across the high phase.
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_qdac_i2c_master.write_byte(b, a);
    check_val({35'h0, a}, {35'h0, exp_ack});
  endtask : wr

  task automatic set_pins(input logic rdy, input logic [1:0] e);
    @(posedge core_clk);
    #1 conv_rdy = rdy;
    ext = e;
  endtask : set_pins

  // Sampled on the falling edge so the pulse is never read in its launch step.
  task automatic wait_upd();
    int n;
    n = 0;
    while (upd !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    if (upd !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
    @(posedge core_clk);
    #1;
  endtask : wait_upd

  // Full update to the local address with a don't-care low byte.
  task automatic upd_full(input logic [7:0] ctrl, input logic [7:0] code);
    sta();
    wr(8'h9c, 1'b1);
    wr(ctrl, 1'b1);
    wr(code, 1'b1);
    wr(8'h00, 1'b1);
  endtask : upd_full

  // Straps moved after power-up must not change the address.
  task automatic t_addr();
    @(posedge core_clk);
    #1 dsel = 2'h0;
    sta();
    wr(8'h98, 1'b0);
    sta();
    wr(8'h00, 1'b0);
    sta();
    wr(8'hf0, 1'b0);
    sta();
    wr(8'h9c, 1'b1);
    sto();
  endtask : t_addr

  task automatic t_update();
    upd_full(8'h14, 8'hff);
    check_val(chan, 36'h0);
    wait_upd();
    check_val(chan, {9'h0, 9'h0ff, 18'h0});
    wr(8'h5a, 1'b1);
    wr(8'hff, 1'b1);
    wait_upd();
    check_val(chan, {9'h0, 9'h05a, 18'h0});
    sto();
  endtask : t_update

  task automatic t_modes();
    upd_full(8'h02, 8'h42);
    sto();
    check_val(chan, {9'h0, 9'h05a, 18'h0});
    upd_full(8'h20, 8'h77);
    wait_upd();
    check_val(chan, {9'h0, 9'h05a, 9'h042, 9'h077});
    sto();
    upd_full(8'h57, 8'h33);
    sto();
    check_val(chan, {9'h0, 9'h05a, 9'h042, 9'h077});
    set_pins(1'b1, 2'h1);
    upd_full(8'h57, 8'h33);
    wait_upd();
    check_val(chan, {9'h133, 9'h05a, 9'h042, 9'h077});
    sto();
    upd_full(8'h40, 8'h11);
    sto();
    upd_full(8'h70, 8'h99);
    wait_upd();
    check_val(chan, {9'h133, 9'h05a, 9'h042, 9'h011});
    sto();
  endtask : t_modes

  // Broadcast in mode 11 ignores the extended address mismatch.
  task automatic t_bcast();
    sta();
    wr(8'h91, 1'b0);
    sta();
    wr(8'h90, 1'b1);
    wr(8'h34, 1'b1);
    wr(8'hc3, 1'b1);
    wr(8'h00, 1'b1);
    wait_upd();
    check_val(chan, {4{9'h0c3}});
    sto();
  endtask : t_bcast

  task automatic t_read();
    logic [7:0] rd;
    sta();
    wr(8'h9d, 1'b1);
    u_qdac_i2c_master.read_byte(1'b1, rd);
    check_val({28'h0, rd}, 36'h0c3);
    u_qdac_i2c_master.read_byte(1'b0, rd);
    check_val({28'h0, rd}, 36'h0c3);
    sto();
  endtask : t_read

  task automatic t_hs();
    sta();
    wr(8'h0b, 1'b0);
    check_val({35'h0, hs}, 36'h1);
    sta();
    wr(8'h9c, 1'b1);
    check_val({35'h0, hs}, 36'h1);
    sto();
    check_val({35'h0, hs}, 36'h0);
  endtask : t_hs

  // Stalled converter: the queue takes eight updates and refuses the ninth.
  task automatic t_fifo();
    int n;
    set_pins(1'b0, 2'h1);
    sta();
    wr(8'h9c, 1'b1);
    wr(8'h54, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      wr(8'(8'h10 + i), 1'b1);
      wr(8'h00, 1'b1);
    end
    wr(8'h18, 1'b1);
    wr(8'h00, 1'b0);
    sto();
    check_val(chan, {4{9'h0c3}});
    set_pins(1'b1, 2'h1);
    n = 0;
    for (int k = 0; k < 40; k++)
    begin
      @(negedge core_clk);
      n += int'(upd);
    end
    check_val(36'(n), 36'h8);
    check_val(chan, {9'h0c3, 9'h017, 9'h0c3, 9'h0c3});
  endtask : t_fifo

  // Main sequence: reset for 10 cycles, then every scenario in turn.
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    check_val(chan, 36'h0);
    check_val({34'h0, hs, sda_oe}, 36'h0);
    t_addr();
    t_update();
    t_modes();
    t_bcast();
    t_read();
    t_hs();
    t_fifo();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
